// ### design/irac_pkg.sv
// Constants, types and divider table for the two-wire rate/address block
// Assumes one 25 MHz MCLK and an AXI4-Lite master with 32-bit data
//
// Overview of operation
// - Serial clock at most MCLK over twenty
// - Position bit picks port A or port B pins
// - Keeps working and interrupting during wait mode
// - Shallow stop freezes activity, registers kept
// - Deep stop returns registers to reset values
// - Own address compared against upper seven bits
// - Multiplier field gives factor one, two, four
// - Rate code selects divider and hold counts
// - Serial period equals multiplier times divider
// - Data changes hold count after clock falls
// - Start holds clock high, then drives low
// - Stop releases data hold count after rise
// - Sixty-four distinct rate settings are selectable
// - Lost arbitration drops to slave, raises event
// - Rate code indexes fixed divider/hold table
package irac_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_OWN = 8'h00; // Own slave address
	localparam logic [7:0] OFF_DIV = 8'h04; // Bit rate divider
	localparam logic [7:0] OFF_CTRL = 8'h08; // Position and master bits
	localparam logic [7:0] OFF_STS = 8'h0C; // Sticky events, write one
	localparam logic [7:0] OFF_MASK = 8'h10; // Interrupt mask
	localparam logic [7:0] OWN_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [2:0] EV_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_POS = 0; // Pin position select
	localparam int CTRL_MASTER = 1; // Master operation
	localparam int EV_ARB = 0; // Arbitration lost
	localparam int EV_MATCH = 1; // Own address seen
	localparam int EV_DONE = 2; // Sequence finished
	localparam int RATE_MULTIPLIER_HI = 7;
	localparam int RATE_MULTIPLIER_LO = 6;
	localparam int RATE_HI = 5;
	localparam logic [1:0] RATE_MULTIPLIER_RSVD = 2'h3;
	localparam logic [15:0] MIN_DIV = 16'h0014; // Fastest allowed period

	// ----------------------------------------------------------------
	// Rate table: divider, data hold, start hold, stop hold, 12 b each
	// ----------------------------------------------------------------
	localparam int TAB_DIV = 36;
	localparam int TAB_SDA = 24;
	localparam int TAB_STA = 12;
	localparam int TAB_STO = 0;
	localparam logic [47:0] RATE_TAB [64] = '{
		48'h01400700600B, 48'h01600700700C, 48'h01800800800D,
		48'h01A00800900E, 48'h01C00900A00F, 48'h01E00900B010,
		48'h02200A00D012, 48'h02800A010015, 48'h01C00700A00F,
		48'h02000700C011, 48'h02400900E013, 48'h028009010015,
		48'h02C00B012017, 48'h03000B014019, 48'h03800D01801D,
		48'h04400D01E023, 48'h030009012019, 48'h03800901601D,
		48'h04000D01A021, 48'h04800D01E025, 48'h050011022029,
		48'h05801102602D, 48'h06801502E035, 48'h08001503A041,
		48'h050009026029, 48'h06000902E031, 48'h070011036039,
		48'h08001103E041, 48'h090019046049, 48'h0A001904E051,
		48'h0C002105E061, 48'h0F0021076079, 48'h0A001104E051,
		48'h0C001105E061, 48'h0E002106E071, 48'h10002107E081,
		48'h12003108E091, 48'h14003109E0A1, 48'h1800410BE0C1,
		48'h1E00410EE0F1, 48'h14002109E0A1, 48'h1800210BE0C1,
		48'h1C00410DE0E1, 48'h2000410FE101, 48'h24006111E121,
		48'h28006113E141, 48'h30008117E181, 48'h3C00811DE1E1,
		48'h28004113E141, 48'h30004117E181, 48'h3800811BE1C1,
		48'h4000811FE201, 48'h4800C123E241, 48'h5000C127E281,
		48'h6001012FE301, 48'h7801013BE3C1, 48'h50008127E281,
		48'h6000812FE301, 48'h70010137E381, 48'h8001013FE401,
		48'h90018147E481, 48'hA001814FE501, 48'hC002015FE601,
		48'hF0020177E781
	};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_START, OP_BIT, OP_STOP} irac_op_t;
	typedef enum {S_IDLE, S_START, S_LOW, S_HIGH, S_STOP_LOW,
		S_STOP_HIGH} irac_state_t;
	typedef struct packed {
		logic valid; // One-cycle request
		irac_op_t op; // Start, one bit, or stop
		logic data; // Bit to send, one releases the line
	} irac_cmd_t;
	typedef struct packed {
		logic valid; // One-cycle address offer
		logic [6:0] addr; // Seven address bits received
	} irac_addr_t;
	typedef struct packed {
		logic [15:0] period; // Serial clock period in MCLK cycles
		logic [15:0] half; // Low and high phase length
		logic [15:0] sda_hold;
		logic [15:0] start_hold;
		logic [15:0] stop_hold;
	} irac_cfg_t;

endpackage

// ### design/irac_top.sv
// Two-wire bus rate/address configuration with its bit-timing sequencer
// Assumes an AXI4-Lite master on MCLK and a byte engine issuing commands
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module irac_top (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire irac_pkg::irac_cmd_t CMD,
	input wire irac_pkg::irac_addr_t ADDR_IN,
	input wire logic SHALLOW_STOP,
	input wire logic DEEP_STOP,
	input wire logic PORT_A_BIT_TWO_IN,
	output logic PORT_A_BIT_TWO_OUT,
	output logic PORT_A_BIT_TWO_OE,
	input wire logic PORT_A_BIT_THREE_IN,
	output logic PORT_A_BIT_THREE_OUT,
	output logic PORT_A_BIT_THREE_OE,
	input wire logic PORT_B_BIT_SIX_IN,
	output logic PORT_B_BIT_SIX_OUT,
	output logic PORT_B_BIT_SIX_OE,
	input wire logic PORT_B_BIT_SEVEN_IN,
	output logic PORT_B_BIT_SEVEN_OUT,
	output logic PORT_B_BIT_SEVEN_OE,
	output logic IRQ,
	output logic MASTER_MODE,
	output logic ARB_LOST,
	output logic SEQ_BUSY,
	output logic SEQ_DONE,
	output logic SEQ_BIT,
	output var irac_pkg::irac_cfg_t CFG
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic rst_all; // System reset or deep stop
	logic [7:0] own_q; // Own slave address register
	logic [7:0] div_q; // Multiplier and rate code
	logic [1:0] ctrl_q; // Master and position bits
	logic [2:0] sts_q; // Sticky events
	logic [2:0] sts_d;
	logic [2:0] mask_q; // Interrupt mask
	logic [2:0] w1c; // Bits software clears this cycle
	logic aw_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic wr_go, rd_go, wr_lo;
	logic [3:0] pin_in; // Raw pin levels
	logic [3:0] sync1_q; // First synchroniser stage
	logic [3:0] sync2_q; // Second stage, safe to use
	logic sda_in, scl_in; // Selected line levels
	irac_pkg::irac_cfg_t cfg_q; // Scaled timing counts
	irac_pkg::irac_state_t st_q; // Sequencer state
	logic [15:0] cnt_q; // Phase counter
	logic sda_drv_q, scl_drv_q; // Pulling the line low
	logic bit_q, done_q, arb_q, rx_q, match_q, irq_q, low_q;
	logic busy_q; // Sequencer not idle, kept in a flop for the pin
	logic [3:0] oe_q; // Pin enables, port B high pair
	logic [47:0] ent; // Selected table entry
	logic [1:0] sh; // Multiplier as shift

	assign rst_all = RST | DEEP_STOP;
	assign wr_lo = aw_rdy_q && S_AXI_WSTRB[0];
	assign pin_in = {PORT_B_BIT_SEVEN_IN, PORT_B_BIT_SIX_IN,
		PORT_A_BIT_THREE_IN, PORT_A_BIT_TWO_IN};

	// ----------------------------------------------------------------
	// Pin input synchronisers, one per pin
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 4; i++) begin : g_sync
		// Lines idle high, so reset to released
		always_ff @(posedge MCLK) begin
			if (RST) begin
				sync1_q[i] <= 1'b1;
				sync2_q[i] <= 1'b1;
			end else begin
				sync1_q[i] <= pin_in[i];
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	// Route the selected pin pair inward
	assign sda_in = ctrl_q[irac_pkg::CTRL_POS] ? sync2_q[2] : sync2_q[0];
	assign scl_in = ctrl_q[irac_pkg::CTRL_POS] ? sync2_q[3] : sync2_q[1];

	// ----------------------------------------------------------------
	// AXI4-Lite slave handshakes
	// ----------------------------------------------------------------
	// Both write channels are taken together, one write in flight
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !aw_rdy_q && !bvalid_q;
	assign rd_go = S_AXI_ARVALID && !ar_rdy_q && !rvalid_q;

	// Write channel and response
	always_ff @(posedge MCLK) begin
		if (RST) begin
			aw_rdy_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= irac_pkg::RESP_OKAY;
		end else begin
			aw_rdy_q <= wr_go;
			if (aw_rdy_q) begin
				bvalid_q <= 1'b1;
				bresp_q <= irac_pkg::RESP_OKAY;
				// Unmapped offsets answer with a slave error
				if ((S_AXI_AWADDR & 8'hFC) > irac_pkg::OFF_MASK) begin
					bresp_q <= irac_pkg::RESP_SLVERR;
				end
			end else if (S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read channel; reads have no side effects
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= irac_pkg::RESP_OKAY;
		end else begin
			ar_rdy_q <= rd_go;
			if (ar_rdy_q) begin
				rvalid_q <= 1'b1;
				rresp_q <= irac_pkg::RESP_OKAY;
				rdata_q <= 32'h00000000;
				case (S_AXI_ARADDR & 8'hFC)
					irac_pkg::OFF_OWN: rdata_q[7:0] <= own_q;
					irac_pkg::OFF_DIV: rdata_q[7:0] <= div_q;
					irac_pkg::OFF_CTRL: rdata_q[1:0] <= ctrl_q;
					irac_pkg::OFF_STS: rdata_q[2:0] <= sts_q;
					irac_pkg::OFF_MASK: rdata_q[2:0] <= mask_q;
					default: rresp_q <= irac_pkg::RESP_SLVERR;
				endcase
			end else if (S_AXI_RREADY) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Address, divider and mask; deep stop clears them like a reset
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			own_q <= irac_pkg::OWN_RST;
			div_q <= irac_pkg::DIV_RST;
			mask_q <= irac_pkg::EV_RST;
		end else if (wr_lo) begin
			case (S_AXI_AWADDR & 8'hFC)
				irac_pkg::OFF_OWN: own_q <= S_AXI_WDATA[7:0];
				irac_pkg::OFF_DIV: div_q <= S_AXI_WDATA[7:0];
				irac_pkg::OFF_MASK: mask_q <= S_AXI_WDATA[2:0];
				default: ;
			endcase
		end
	end

	// Control; lost arbitration beats a software write of master
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			ctrl_q <= irac_pkg::CTRL_RST;
		end else begin
			if (wr_lo && (S_AXI_AWADDR & 8'hFC) == irac_pkg::OFF_CTRL) begin
				ctrl_q <= S_AXI_WDATA[1:0];
			end
			if (arb_q) begin
				ctrl_q[irac_pkg::CTRL_MASTER] <= 1'b0;
			end
		end
	end

	// Sticky events: a new event wins over the write-one clear
	assign w1c = (wr_lo && (S_AXI_AWADDR & 8'hFC) == irac_pkg::OFF_STS) ?
		S_AXI_WDATA[2:0] : 3'h0;
	assign sts_d = (sts_q & ~w1c) | {done_q, match_q, arb_q};
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			sts_q <= irac_pkg::EV_RST;
		end else begin
			sts_q <= sts_d;
		end
	end

	// Interrupt level; nothing here looks at wait mode, so it still wakes
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(sts_q & mask_q);
		end
	end

	// Own address compare, seven offered bits against own_q[7:1]
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			match_q <= 1'b0;
		end else begin
			match_q <= ADDR_IN.valid && !SHALLOW_STOP &&
				ADDR_IN.addr == own_q[7:1];
		end
	end

	// ----------------------------------------------------------------
	// Timing counts from the rate table
	// ----------------------------------------------------------------
	// Any of 64 codes picks one row; reserved multiplier counts as one
	assign ent = irac_pkg::RATE_TAB[div_q[irac_pkg::RATE_HI:0]];
	assign sh = (div_q[irac_pkg::RATE_MULTIPLIER_HI:irac_pkg::RATE_MULTIPLIER_LO] ==
		irac_pkg::RATE_MULTIPLIER_RSVD) ? 2'h0 :
		div_q[irac_pkg::RATE_MULTIPLIER_HI:irac_pkg::RATE_MULTIPLIER_LO];

	// Registered so the long multiplexer stays off the sequencer path
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			cfg_q <= '0;
		end else begin
			cfg_q.period <= {4'h0, ent[irac_pkg::TAB_DIV +: 12]} << sh;
			cfg_q.half <= {5'h00, ent[irac_pkg::TAB_DIV + 1 +: 11]} << sh;
			cfg_q.sda_hold <= {4'h0, ent[irac_pkg::TAB_SDA +: 12]} << sh;
			cfg_q.start_hold <= {4'h0, ent[irac_pkg::TAB_STA +: 12]} << sh;
			cfg_q.stop_hold <= {4'h0, ent[irac_pkg::TAB_STO +: 12]} << sh;
		end
	end

	// ----------------------------------------------------------------
	// Bit-timing sequencer
	// ----------------------------------------------------------------
	// One start, bit or stop per request; only taken while master
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			st_q <= irac_pkg::S_IDLE;
			cnt_q <= 16'h0000;
			sda_drv_q <= 1'b0;
			scl_drv_q <= 1'b0;
			bit_q <= 1'b0;
			rx_q <= 1'b0;
			done_q <= 1'b0;
			arb_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (SHALLOW_STOP) begin
			// Frozen in place, lines hold their level
			done_q <= 1'b0;
			arb_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			arb_q <= 1'b0;
			cnt_q <= cnt_q + 16'h0001;
			case (st_q)
				irac_pkg::S_IDLE: begin
					cnt_q <= 16'h0000;
					if (CMD.valid && ctrl_q[irac_pkg::CTRL_MASTER]) begin
						bit_q <= CMD.data;
						busy_q <= 1'b1;
						case (CMD.op)
							irac_pkg::OP_START: begin
								sda_drv_q <= 1'b1;
								st_q <= irac_pkg::S_START;
							end
							irac_pkg::OP_BIT: begin
								scl_drv_q <= 1'b1;
								st_q <= irac_pkg::S_LOW;
							end
							default: begin
								scl_drv_q <= 1'b1;
								st_q <= irac_pkg::S_STOP_LOW;
							end
						endcase
					end
				end
				// Clock stays high through the start hold
				irac_pkg::S_START: begin
					if (cnt_q == cfg_q.start_hold - 16'h0001) begin
						scl_drv_q <= 1'b1;
						done_q <= 1'b1;
						st_q <= irac_pkg::S_IDLE;
						busy_q <= 1'b0;
					end
				end
				// Data may only move once the hold after the fall is over
				irac_pkg::S_LOW: begin
					if (cnt_q == cfg_q.sda_hold - 16'h0001) begin
						sda_drv_q <= !bit_q;
					end
					if (cnt_q == cfg_q.half - 16'h0001) begin
						scl_drv_q <= 1'b0;
						cnt_q <= 16'h0000;
						st_q <= irac_pkg::S_HIGH;
					end
				end
				// A slave or other master holding the clock stretches it
				irac_pkg::S_HIGH: begin
					if (!scl_in) begin
						cnt_q <= cnt_q;
					end else if (cnt_q == cfg_q.half - 16'h0001) begin
						rx_q <= sda_in;
						if (bit_q && !sda_in) begin
							// Someone else pulled data low: back off
							sda_drv_q <= 1'b0;
							scl_drv_q <= 1'b0;
							arb_q <= 1'b1;
						end else begin
							scl_drv_q <= 1'b1;
							done_q <= 1'b1;
						end
						st_q <= irac_pkg::S_IDLE;
						busy_q <= 1'b0;
					end
				end
				irac_pkg::S_STOP_LOW: begin
					sda_drv_q <= 1'b1;
					if (cnt_q == cfg_q.half - 16'h0001) begin
						scl_drv_q <= 1'b0;
						cnt_q <= 16'h0000;
						st_q <= irac_pkg::S_STOP_HIGH;
					end
				end
				irac_pkg::S_STOP_HIGH: begin
					if (cnt_q == cfg_q.stop_hold - 16'h0001) begin
						sda_drv_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= irac_pkg::S_IDLE;
						busy_q <= 1'b0;
					end
				end
				default: begin
					st_q <= irac_pkg::S_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin enables and status outputs
	// ----------------------------------------------------------------
	// Unselected pair is never driven; costs one cycle of pin latency
	always_ff @(posedge MCLK) begin
		if (rst_all) begin
			oe_q <= 4'h0;
			low_q <= 1'b0;
		end else begin
			oe_q <= ctrl_q[irac_pkg::CTRL_POS] ?
				{scl_drv_q, sda_drv_q, 2'h0} :
				{2'h0, scl_drv_q, sda_drv_q};
			low_q <= 1'b0; // Open drain: only ever pulls low
		end
	end

	assign S_AXI_AWREADY = aw_rdy_q;
	assign S_AXI_WREADY = aw_rdy_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = ar_rdy_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign PORT_A_BIT_TWO_OE = oe_q[0];
	assign PORT_A_BIT_THREE_OE = oe_q[1];
	assign PORT_B_BIT_SIX_OE = oe_q[2];
	assign PORT_B_BIT_SEVEN_OE = oe_q[3];
	assign PORT_A_BIT_TWO_OUT = low_q;
	assign PORT_A_BIT_THREE_OUT = low_q;
	assign PORT_B_BIT_SIX_OUT = low_q;
	assign PORT_B_BIT_SEVEN_OUT = low_q;
	assign IRQ = irq_q;
	assign MASTER_MODE = ctrl_q[irac_pkg::CTRL_MASTER];
	assign ARB_LOST = arb_q;
	assign SEQ_BUSY = busy_q;
	assign SEQ_DONE = done_q;
	assign SEQ_BIT = rx_q;
	assign CFG = cfg_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	irac_pkg::irac_state_t prev_q; // Helper: state one cycle ago
	logic [15:0] age_q; // Helper: cycles spent in current state
	always_ff @(posedge MCLK) begin
		prev_q <= st_q;
		age_q <= (st_q != prev_q) ? 16'h0001 : age_q + 16'h0001;
	end

	AST_MIN_PERIOD: assert property (cfg_q.period == 16'h0000 ||
		cfg_q.period >= irac_pkg::MIN_DIV) else $error("period too short");
	AST_PIN_ROUTE: assert property (!$past(ctrl_q[0]) |->
		!PORT_B_BIT_SIX_OE && !PORT_B_BIT_SEVEN_OE) else $error("bad pins");
	AST_IRQ: assert property (arb_q && mask_q[0] && !DEEP_STOP ##1
		mask_q[0] && !DEEP_STOP |=> IRQ) else $error("no interrupt");
	AST_SHALLOW: assert property (SHALLOW_STOP && !DEEP_STOP |=>
		$stable(st_q) && $stable(cnt_q)) else $error("ran in stop");
	AST_DEEP: assert property (DEEP_STOP |=> own_q == 8'h00 &&
		div_q == 8'h00) else $error("deep stop kept state");
	AST_MATCH: assert property (ADDR_IN.valid && !SHALLOW_STOP &&
		!DEEP_STOP && ADDR_IN.addr == own_q[7:1] |=> match_q)
		else $error("address missed");
	AST_RATE_MULTIPLIER: assert property (div_q[7:6] == 2'h2 && !DEEP_STOP |=>
		cfg_q.period == {2'h0, irac_pkg::RATE_TAB[$past(div_q[5:0])]
		[47:36], 2'h0}) else $error("factor four wrong");
	AST_TABLE0: assert property (div_q == 8'h00 && !DEEP_STOP |=>
		cfg_q.period == 16'h0014 && cfg_q.stop_hold == 16'h000B)
		else $error("row zero wrong");
	AST_SDA_HOLD: assert property (st_q == irac_pkg::S_LOW &&
		$changed(sda_drv_q) |-> age_q == cfg_q.sda_hold)
		else $error("data hold wrong");
	AST_START_HOLD: assert property ($rose(scl_drv_q) &&
		$past(st_q) == irac_pkg::S_START |-> age_q == cfg_q.start_hold)
		else $error("start hold wrong");
	AST_STOP_HOLD: assert property ($fell(sda_drv_q) &&
		$past(st_q) == irac_pkg::S_STOP_HIGH && !$past(SHALLOW_STOP)
		|-> age_q == cfg_q.stop_hold) else $error("stop hold wrong");
	AST_ARB: assert property (arb_q |-> !sda_drv_q && !scl_drv_q ##1
		!ctrl_q[1]) else $error("still master after loss");
	AST_READBACK: assert property (wr_lo && !DEEP_STOP &&
		(S_AXI_AWADDR & 8'hFC) == 8'h04 |=> div_q == $past(S_AXI_WDATA[7:0]))
		else $error("divider not stored");

	COV_START: cover property ($past(st_q) == irac_pkg::S_START && done_q);
	COV_BIT: cover property ($past(st_q) == irac_pkg::S_HIGH && done_q);
	COV_STOP: cover property ($past(st_q) == irac_pkg::S_STOP_HIGH && done_q);
	COV_ARB: cover property (arb_q);

endmodule
`default_nettype wire

// ### tb/irac_bus_model.sv
// Two-wire bus far side: pull-up wires plus another party's pull-down
// Assumes the design's enables mean "pull the line low"
`timescale 1ns/10ps
`default_nettype none
module irac_bus_model (
	input wire logic data_oe,
	input wire logic clk_oe,
	input wire logic hold_data_low,
	output logic data_line,
	output logic clk_line
);
	// ----------------------------------------
	// Wired-AND lines
	// ----------------------------------------
	// Pull-up: a released line reads high
	assign data_line = !(data_oe | hold_data_low);
	// No other master stretches the clock here
	assign clk_line = !clk_oe;
endmodule
`default_nettype wire

// ### tb/i2c_rate_and_address_config_tb_top.sv
// Ordered tests over AXI, command port and bus wires of the block
// Assumes the package and the bus model are compiled first
`timescale 1ns/10ps
`default_nettype none
module i2c_rate_and_address_config_tb_top;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic mclk = 0, rst = 1, aw = 0, wv = 0, ar = 0, br = 0, rr = 0;
	logic shal = 0, deep = 0, hold_low = 0, lost = 0;
	logic [7:0] addr = 0;
	logic [31:0] wd = 0, q, rdata;
	logic [1:0] r, bresp, rresp;
	logic awr, wrr, bv, arr, rv, sda, scl, a2e, a3e, b6e, b7e;
	logic irq, mst, arb, busy, sdone, sbit;
	irac_pkg::irac_cmd_t cmd_q = '0;
	irac_pkg::irac_addr_t adr_q = '0;
	irac_pkg::irac_cfg_t cfgw;
	int mismatches = 0, checks_done = 0, cyc = 0, t_sf, t_cf, t_cr, t_sr;
	logic sda_p = 1, scl_p = 1;
	always #20 mclk = ~mclk;
	irac_bus_model bus (.data_oe(a2e), .clk_oe(a3e), .hold_data_low(hold_low),
		.data_line(sda), .clk_line(scl));
	// Write strobe tied: only lane 0 carries register bits
	irac_top dut (.MCLK(mclk), .RST(rst), .S_AXI_AWADDR(addr),
		.S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(addr), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rr), .CMD(cmd_q), .ADDR_IN(adr_q), .SHALLOW_STOP(shal),
		.DEEP_STOP(deep), .PORT_A_BIT_TWO_IN(sda), .PORT_A_BIT_TWO_OUT(),
		.PORT_A_BIT_TWO_OE(a2e), .PORT_A_BIT_THREE_IN(scl),
		.PORT_A_BIT_THREE_OUT(), .PORT_A_BIT_THREE_OE(a3e),
		.PORT_B_BIT_SIX_IN(!b6e), .PORT_B_BIT_SIX_OUT(), .PORT_B_BIT_SIX_OE(b6e),
		.PORT_B_BIT_SEVEN_IN(!b7e), .PORT_B_BIT_SEVEN_OUT(),
		.PORT_B_BIT_SEVEN_OE(b7e), .IRQ(irq), .MASTER_MODE(mst), .ARB_LOST(arb),
		.SEQ_BUSY(busy), .SEQ_DONE(sdone), .SEQ_BIT(sbit), .CFG(cfgw));
	// ----------------------------------------
	// Wire edge timestamps, in MCLK cycles
	// ----------------------------------------
	always @(posedge mclk) begin
		cyc++;
		if (sda_p & !sda) t_sf = cyc;
		if (!sda_p & sda) t_sr = cyc;
		if (scl_p & !scl) t_cf = cyc;
		if (!scl_p & scl) t_cr = cyc;
		sda_p = sda;
		scl_p = scl;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One AXI transfer; readies held until the answer is sampled
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		aw <= w; wv <= w; ar <= !w; addr <= a; wd <= d; br <= 1; rr <= 1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			if (awr) aw <= 0;
			if (wrr) wv <= 0;
			if (arr) ar <= 0;
		end while (!(w ? bv : rv));
		q = rdata;
		r = w ? bresp : rresp;
		br <= 0;
		rr <= 0;
		// Answer one cycle after the ready pulse, so three edges in all
		chk(n, 3);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		xfer(1, a, d);
		chk(r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		xfer(0, a, 0);
		chk(q, e);
		chk(r, er);
	endtask
	task automatic cfg(input logic [7:0] v, input int m, dv, sh, st, sp);
		wr(irac_pkg::OFF_DIV, v, 0);
		repeat (2) @(posedge mclk);
		chk(cfgw.period, m * dv);
		chk(cfgw.half, m * dv / 2);
		chk(cfgw.sda_hold, m * sh);
		chk(cfgw.start_hold, m * st);
		chk(cfgw.stop_hold, m * sp);
	endtask
	// One sequencer step, waiting for its completion pulse
	task automatic cmd(input irac_pkg::irac_op_t op, input logic d);
		int n;
		@(posedge mclk);
		cmd_q <= '{1'b1, op, d};
		@(posedge mclk);
		cmd_q <= '0;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			lost = arb;
		end while (!(sdone | arb) && n < 3000);
		chk(n < 3000, 1);
	endtask
	task automatic offer(input logic [6:0] a);
		@(posedge mclk);
		adr_q <= '{1'b1, a};
		@(posedge mclk);
		adr_q <= '0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 0;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 0, 0);
		$display("test reset done");
		cfg(8'h47, 2, 40, 10, 16, 21);
		cfg(8'h8B, 4, 40, 9, 16, 21);
		cfg(8'h38, 1, 1280, 129, 638, 641);
		cfg(8'h00, 1, 20, 7, 6, 11);
		wr(8'h14, 1, 2);
		rd(8'h14, 0, 2);
		$display("test rates done");
		wr(irac_pkg::OFF_OWN, 32'hA4, 0);
		rd(irac_pkg::OFF_OWN, 32'hA4, 0);
		offer(7'h53);
		rd(irac_pkg::OFF_STS, 0, 0);
		offer(7'h52);
		rd(irac_pkg::OFF_STS, 2, 0);
		chk(irq, 0);
		wr(irac_pkg::OFF_MASK, 3, 0);
		repeat (2) @(posedge mclk);
		chk(irq, 1);
		wr(irac_pkg::OFF_STS, 2, 0);
		repeat (2) @(posedge mclk);
		chk(irq, 0);
		$display("test interrupt done");
		wr(irac_pkg::OFF_CTRL, 2, 0);
		cmd(irac_pkg::OP_START, 0);
		// Pin enables lag the done pulse; let the wire stamps catch up
		repeat (2) @(posedge mclk);
		chk(t_cf - t_sf, 6);
		// Another master keeps data low while we send a one
		hold_low <= 1;
		cmd(irac_pkg::OP_BIT, 1);
		chk(lost, 1);
		@(posedge mclk);
		chk(mst, 0);
		hold_low <= 0;
		rd(irac_pkg::OFF_STS, 5, 0);
		chk(irq, 1);
		wr(irac_pkg::OFF_CTRL, 2, 0);
		cmd(irac_pkg::OP_START, 0);
		cmd(irac_pkg::OP_BIT, 0);
		chk(sbit, 0);
		cmd(irac_pkg::OP_STOP, 0);
		repeat (2) @(posedge mclk);
		chk(t_sr - t_cr, 11);
		$display("test sequencer done");
		shal <= 1;
		@(posedge mclk);
		cmd_q <= '{1'b1, irac_pkg::OP_START, 1'b0};
		@(posedge mclk);
		cmd_q <= '0;
		repeat (3) @(posedge mclk);
		chk(busy, 0);
		shal <= 0;
		rd(irac_pkg::OFF_OWN, 32'hA4, 0);
		wr(irac_pkg::OFF_CTRL, 3, 0);
		cmd(irac_pkg::OP_START, 0);
		chk(b6e, 1);
		chk(a2e, 0);
		deep <= 1;
		repeat (2) @(posedge mclk);
		deep <= 0;
		repeat (2) @(posedge mclk);
		rd(irac_pkg::OFF_OWN, 0, 0);
		rd(irac_pkg::OFF_CTRL, 0, 0);
		chk(cfgw.period, 20);
		$display("test stop modes done");
		finish_test();
	end
	// Hang guard, well past the expected few hundred cycles
	initial begin
		#800us;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
